/* File: hdl/rfpc_pkg.sv */
// constants for the receive frequency tracking and polling control block
package rfpc_pkg;
    localparam logic [6:0]  ADDR_BANK_LAST = 7'h0E;
    localparam logic [6:0]  ADDR_LO_HI     = 7'h09;
    localparam logic [6:0]  ADDR_LO_LO     = 7'h0B;
    localparam logic [6:0]  ADDR_PREAMBLE  = 7'h0C;
    localparam logic [6:0]  ADDR_FEI       = 7'h11;
    localparam logic [6:0]  ADDR_STATE     = 7'h14;
    localparam logic [6:0]  ADDR_WAKE_DET  = 7'h17;
    localparam logic [6:0]  ADDR_RATIO     = 7'h18;
    localparam logic [6:0]  ADDR_FRONTEND  = 7'h19;
    localparam int          BANK_LEN       = 15;
    localparam int          IDX_LO_HI      = 9;
    localparam int          IDX_LO_MID     = 10;
    localparam int          IDX_LO_LO      = 11;
    localparam int          IDX_PREAMBLE   = 12;
    localparam int          IDX_RANGE      = 1;
    localparam int          IDX_FILTER     = 2;
    localparam int          IF_BIT         = 3;
    localparam int          CHF_MSB        = 2;
    localparam int          RANGE_MSB      = 2;
    localparam int          PRE_MSB        = 3;
    localparam int          RATIO_MSB      = 6;
    localparam int          ST_ENABLE_BIT  = 0;
    localparam int          ST_RXEN_BIT    = 2;
    localparam int          ST_POLL_BIT    = 3;
    localparam logic [7:0]  ST_RUN_VALUE   = 8'h05;
    localparam logic [7:0]  ST_SLEEP_VALUE = 8'h00;
    localparam logic [7:0]  RESET_BYTE     = 8'h00;
    localparam logic signed [9:0] FEI_LIMIT  = 10'sd112;
    localparam logic [3:0]  RANGE_STEP_SH  = 4'd4;
    localparam int          LO_RES_EXP     = 16;
    localparam int          AFC_EXP_BASE   = 14;
    localparam int          CORR_SHIFT     = LO_RES_EXP - AFC_EXP_BASE;
    localparam int          CLK_PERIOD_PS  = 10000;
    localparam int          DET_BASE_PS    = 480000000;
    localparam int          DET_STEP_PS    = 80000000;
    localparam int          DET_BASE_CYC   = (DET_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          DET_STEP_CYC   = (DET_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    typedef enum logic [3:0] {
        ST_SLEEP   = 4'b0001,
        ST_STANDBY = 4'b0010,
        ST_RX      = 4'b0100,
        ST_POLL    = 4'b1000
    } rfpc_mode_t;
endpackage : rfpc_pkg

/* File: hdl/rfpc_timer_if.sv */
// carrier between the controller and its polling window timer
`timescale 1ns/100ps
interface rfpc_timer_if;
    logic       run;
    logic [7:0] det_count;
    logic [6:0] ratio;
    logic       detect_on;
    logic       cycle_wrap;
    modport ctrl  (output run, output det_count, output ratio, input detect_on, input cycle_wrap);
    modport timer (input run, input det_count, input ratio, output detect_on, output cycle_wrap);
endinterface : rfpc_timer_if

/* File: hdl/rfpc_poll_timer.sv */
// detect window and idle time sequencer for polled reception
`timescale 1ns/100ps
module rfpc_poll_timer #(
    parameter int DET_BASE = rfpc_pkg::DET_BASE_CYC,
    parameter int DET_STEP = rfpc_pkg::DET_STEP_CYC
) (
    input  wire logic      sys_clk,
    input  wire logic      sys_rst,
    input  wire logic      ce,
    rfpc_timer_if.timer    tif
);
    typedef struct packed {
        logic        detect;
        logic [31:0] cnt;
        logic [7:0]  rep;
        logic        wrap;
    } rfpc_tmr_t;

    rfpc_tmr_t s_r, s_nxt;
    logic [31:0] win_len;

    always_comb begin
        win_len = 32'(DET_BASE) + 32'(tif.det_count) * 32'(DET_STEP); // RQ13
        s_nxt = s_r;
        s_nxt.wrap = 1'b0;
        if (!tif.run) begin
            s_nxt.detect = 1'b1;
            s_nxt.cnt = 32'h0000_0000;
            s_nxt.rep = 8'h00;
        end else if (s_r.cnt + 32'h0000_0001 >= win_len) begin
            s_nxt.cnt = 32'h0000_0000;
            if (s_r.detect) begin
                s_nxt.detect = 1'b0;
                s_nxt.rep = 8'h00;
            end else if (s_r.rep >= {1'b0, tif.ratio}) begin // RQ12
                s_nxt.detect = 1'b1;
                s_nxt.wrap = 1'b1;
            end else begin
                s_nxt.rep = s_r.rep + 8'h01;
            end
        end else begin
            s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '{detect: 1'b1, cnt: 32'h0000_0000, rep: 8'h00, wrap: 1'b0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign tif.detect_on  = s_r.detect & tif.run;
    assign tif.cycle_wrap = s_r.wrap;
endmodule : rfpc_poll_timer

/* File: hdl/rfpc_ctrl.sv */
// register file, mode control, error reporting and tuning word for the receiver
// Function
// RQ1 - error index reads as signed integer within minus 112 to plus 112
// RQ2 - oversized mismatch saturates the index at 112 instead of wrapping
// RQ3 - correction offset equals index times crystal over two to (if+chf+14)
// RQ4 - index is valid right after a packet is recognized in receive
// RQ5 - centre word changes only outside receive; host leaves receive first
// RQ6 - synthesizer step is crystal over two to sixteen per centre count
// RQ7 - host corrects centre word by index times four over two to (if+chf)
// RQ8 - host raises word for positive index, lowers for negative
// RQ9 - host retunes via standby, writing three bytes from 0x09, then re-enters
// RQ10 - index readable as a byte at address 0x11
// RQ11 - preamble length is field in bits 3:0 of 0x0C plus one
// RQ12 - polling duty cycle is one over two plus seven-bit ratio
// RQ13 - detect window is 0.48 ms plus count times 0.08 ms
// RQ14 - host makes detect window exceed twice preamble bits minus one
// RQ15 - host sets both preamble match words to zero for Manchester preamble
// RQ16 - configuration bank is fifteen bytes from 0x00 written sequentially
// RQ17 - correction range scales from zero to full by limit 0 to 7
// RQ18 - writing 0x05 to 0x14 enters receive, 0x00 returns to sleep
// RQ19 - index byte is eight-bit two's complement
`timescale 1ns/100ps
module rfpc_ctrl #(
    parameter int DET_BASE = rfpc_pkg::DET_BASE_CYC,
    parameter int DET_STEP = rfpc_pkg::DET_STEP_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_mosi,
    output logic             spi_miso_o,
    output logic             spi_miso_oe,
    input  wire logic        packet_seen,
    input  wire logic [9:0]  afc_error,
    input  wire logic        preamble_found,
    output logic [23:0]      synth_word_r,
    output logic [4:0]       preamble_bits_r,
    output logic [3:0]       mode_r,
    output logic             detect_on_r,
    output logic [7:0]       frontend_r
);
    typedef struct packed {
        logic [14:0][7:0]     bank;
        logic [7:0]           frequency_error_index;
        logic [7:0]           st_ctl;
        logic [7:0]           wake_det;
        logic [7:0]           ratio;
        logic [7:0]           frontend;
        rfpc_pkg::rfpc_mode_t mode;
        logic                 sclk_q;
        logic [2:0]           bitc;
        logic [7:0]           shin;
        logic [7:0]           shout;
        logic                 first;
        logic                 wr;
        logic [6:0]           addr;
        logic                 miso;
        logic                 miso_oe;
        logic [23:0]          synth;
        logic                 det_on;
        logic [4:0]           pre;
    } rfpc_state_t;

    rfpc_state_t s_r, s_nxt;
    rfpc_timer_if tif ();

    function automatic logic [7:0] reg_read(input rfpc_state_t s, input logic [6:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a <= rfpc_pkg::ADDR_BANK_LAST) d = s.bank[4'(a)]; // RQ16
        else if (a == rfpc_pkg::ADDR_FEI) d = s.frequency_error_index; // RQ10
        else if (a == rfpc_pkg::ADDR_STATE) d = s.st_ctl;
        else if (a == rfpc_pkg::ADDR_WAKE_DET) d = s.wake_det;
        else if (a == rfpc_pkg::ADDR_RATIO) d = {1'b0, s.ratio[rfpc_pkg::RATIO_MSB:0]};
        else if (a == rfpc_pkg::ADDR_FRONTEND) d = s.frontend;
        return d;
    endfunction : reg_read

    function automatic logic [7:0] saturate(input logic signed [9:0] e, input logic [2:0] lim);
        logic signed [9:0] l;
        l = $signed({3'b000, lim, 4'b0000}); // RQ17
        if (l > rfpc_pkg::FEI_LIMIT) l = rfpc_pkg::FEI_LIMIT;
        if (e > l) return 8'(l); // RQ2
        if (e < -l) return 8'(-l); // RQ2
        return 8'(e); // RQ19
    endfunction : saturate

    logic        rise;
    logic        fall;
    logic [7:0]  rx_byte;
    logic [23:0] lo_word;
    logic [3:0]  shift_sel;
    logic signed [25:0] corr;
    logic        st_en;
    logic        st_rx;
    logic        st_poll;
    logic        st_wr;

    assign tif.run       = (s_r.mode == rfpc_pkg::ST_POLL);
    assign tif.det_count = s_r.wake_det;
    assign tif.ratio     = s_r.ratio[rfpc_pkg::RATIO_MSB:0];

    rfpc_poll_timer #(.DET_BASE(DET_BASE), .DET_STEP(DET_STEP)) u_timer (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .tif     (tif)
    );

    always_comb begin
        s_nxt = s_r;
        st_wr = 1'b0;
        rise = spi_sclk & ~s_r.sclk_q;
        fall = ~spi_sclk & s_r.sclk_q;
        rx_byte = {s_r.shin[6:0], spi_mosi};
        s_nxt.sclk_q = spi_sclk;
        if (spi_cs_n) begin
            s_nxt.bitc = 3'd0;
            s_nxt.first = 1'b1;
            s_nxt.miso_oe = 1'b0;
            s_nxt.miso = 1'b0;
        end else begin
            s_nxt.miso_oe = 1'b1;
            if (rise) begin
                s_nxt.shin = rx_byte;
                s_nxt.bitc = s_r.bitc + 3'd1;
                if (s_r.bitc == 3'd7) begin
                    if (s_r.first) begin
                        s_nxt.first = 1'b0;
                        s_nxt.wr = rx_byte[7];
                        s_nxt.addr = rx_byte[6:0];
                        s_nxt.shout = reg_read(s_r, rx_byte[6:0]);
                    end else begin
                        if (s_r.wr) begin
                            if (s_r.addr <= rfpc_pkg::ADDR_BANK_LAST) begin
                                if (!(s_r.mode == rfpc_pkg::ST_RX && s_r.addr >= rfpc_pkg::ADDR_LO_HI
                                      && s_r.addr <= rfpc_pkg::ADDR_LO_LO)) // RQ5
                                    s_nxt.bank[4'(s_r.addr)] = rx_byte; // RQ16
                            end else if (s_r.addr == rfpc_pkg::ADDR_STATE) begin
                                s_nxt.st_ctl = rx_byte; // RQ18
                                st_wr = 1'b1;
                            end else if (s_r.addr == rfpc_pkg::ADDR_WAKE_DET) s_nxt.wake_det = rx_byte;
                            else if (s_r.addr == rfpc_pkg::ADDR_RATIO) s_nxt.ratio = rx_byte;
                            else if (s_r.addr == rfpc_pkg::ADDR_FRONTEND) s_nxt.frontend = rx_byte;
                        end
                        s_nxt.addr = s_r.addr + 7'd1; // RQ16
                        s_nxt.shout = reg_read(s_r, s_r.addr + 7'd1);
                    end
                end
            end else if (fall) begin
                s_nxt.miso = s_r.shout[7];
                s_nxt.shout = {s_r.shout[6:0], 1'b0};
            end
        end

        st_en = s_nxt.st_ctl[rfpc_pkg::ST_ENABLE_BIT];
        st_rx = s_nxt.st_ctl[rfpc_pkg::ST_RXEN_BIT];
        st_poll = s_nxt.st_ctl[rfpc_pkg::ST_POLL_BIT];
        case (s_r.mode)
            rfpc_pkg::ST_SLEEP, rfpc_pkg::ST_STANDBY: begin
                if (!st_en) s_nxt.mode = rfpc_pkg::ST_SLEEP; // RQ18
                else if (st_rx) s_nxt.mode = rfpc_pkg::ST_RX; // RQ18
                else if (st_poll) s_nxt.mode = rfpc_pkg::ST_POLL;
                else s_nxt.mode = rfpc_pkg::ST_STANDBY; // RQ5
            end
            // a wake from polling stays in receive until the host writes the state byte
            rfpc_pkg::ST_RX: begin
                if (!st_en) s_nxt.mode = rfpc_pkg::ST_SLEEP; // RQ18
                else if (st_rx) s_nxt.mode = rfpc_pkg::ST_RX; // RQ18
                else if (!st_poll) s_nxt.mode = rfpc_pkg::ST_STANDBY; // RQ5
                else if (st_wr) s_nxt.mode = rfpc_pkg::ST_POLL;
            end
            rfpc_pkg::ST_POLL: begin
                if (!st_en) s_nxt.mode = rfpc_pkg::ST_SLEEP;
                else if (st_rx || (tif.detect_on && preamble_found)) s_nxt.mode = rfpc_pkg::ST_RX;
                else if (!st_poll) s_nxt.mode = rfpc_pkg::ST_STANDBY;
            end
            default: s_nxt.mode = rfpc_pkg::ST_SLEEP;
        endcase
        s_nxt.det_on = tif.detect_on;
        s_nxt.pre = {1'b0, s_nxt.bank[rfpc_pkg::IDX_PREAMBLE][rfpc_pkg::PRE_MSB:0]} + 5'h01; // RQ11

        if (s_r.mode == rfpc_pkg::ST_RX && packet_seen) // RQ4
            s_nxt.frequency_error_index = saturate($signed(afc_error), s_r.bank[rfpc_pkg::IDX_RANGE][rfpc_pkg::RANGE_MSB:0]); // RQ1

        lo_word = {s_r.bank[rfpc_pkg::IDX_LO_HI], s_r.bank[rfpc_pkg::IDX_LO_MID], s_r.bank[rfpc_pkg::IDX_LO_LO]};
        shift_sel = {3'b000, s_r.bank[rfpc_pkg::IDX_FILTER][rfpc_pkg::IF_BIT]}
                  + {1'b0, s_r.bank[rfpc_pkg::IDX_FILTER][rfpc_pkg::CHF_MSB:0]};
        corr = ($signed({{18{s_r.frequency_error_index[7]}}, s_r.frequency_error_index}) <<< rfpc_pkg::CORR_SHIFT) >>> shift_sel; // RQ3
        if (s_r.mode == rfpc_pkg::ST_RX)
            s_nxt.synth = 24'($signed({2'b00, lo_word}) + corr); // RQ6
        else
            s_nxt.synth = lo_word; // RQ6
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '{bank: '0, frequency_error_index: rfpc_pkg::RESET_BYTE, st_ctl: rfpc_pkg::ST_SLEEP_VALUE,
                     wake_det: rfpc_pkg::RESET_BYTE, ratio: rfpc_pkg::RESET_BYTE,
                     frontend: rfpc_pkg::RESET_BYTE, mode: rfpc_pkg::ST_SLEEP, sclk_q: 1'b0,
                     bitc: 3'd0, shin: 8'h00, shout: 8'h00, first: 1'b1, wr: 1'b0, addr: 7'h00,
                     miso: 1'b0, miso_oe: 1'b0, synth: 24'h00_0000, det_on: 1'b0, pre: 5'h01};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign spi_miso_o      = s_r.miso;
    assign spi_miso_oe     = s_r.miso_oe;
    assign synth_word_r    = s_r.synth;
    assign preamble_bits_r = s_r.pre; // RQ11
    assign mode_r          = s_r.mode;
    assign detect_on_r     = s_r.det_on;
    assign frontend_r      = s_r.frontend;

    property p_fei_range;
        @(posedge sys_clk) disable iff (sys_rst)
        $signed(s_r.frequency_error_index) <= 8'sd112 && $signed(s_r.frequency_error_index) >= -8'sd112;
    endproperty
    a_fei_range: assert property (p_fei_range) else $error("error index out of range"); // RQ1

    property p_fei_sat;
        @(posedge sys_clk) disable iff (sys_rst)
        ce && s_r.mode == rfpc_pkg::ST_RX && packet_seen && $signed(afc_error) > 10'sd112
            && s_r.bank[rfpc_pkg::IDX_RANGE][2:0] == 3'd7 |=> s_r.frequency_error_index == 8'h70;
    endproperty
    a_fei_sat: assert property (p_fei_sat) else $error("error index did not saturate"); // RQ2

    property p_fei_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        !(s_r.mode == rfpc_pkg::ST_RX && packet_seen) |=> $stable(s_r.frequency_error_index);
    endproperty
    a_fei_hold: assert property (p_fei_hold) else $error("error index changed without a packet"); // RQ4

    property p_lo_locked;
        @(posedge sys_clk) disable iff (sys_rst)
        s_r.mode == rfpc_pkg::ST_RX && $past(s_r.mode) == rfpc_pkg::ST_RX
            |-> lo_word == $past(lo_word);
    endproperty
    a_lo_locked: assert property (p_lo_locked) else $error("centre word changed in receive"); // RQ5

    property p_synth_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        ce && s_r.mode != rfpc_pkg::ST_RX ##1 ce && s_r.mode != rfpc_pkg::ST_RX |=> synth_word_r == $past(lo_word);
    endproperty
    a_synth_idle: assert property (p_synth_idle) else $error("synth word differs from centre word"); // RQ6

    property p_preamble;
        @(posedge sys_clk) disable iff (sys_rst)
        preamble_bits_r == 5'(s_r.bank[12][3:0]) + 5'd1 && preamble_bits_r != 5'd0;
    endproperty
    a_preamble: assert property (p_preamble) else $error("preamble length wrong"); // RQ11

    property p_run_enters_rx;
        @(posedge sys_clk) disable iff (sys_rst)
        s_r.st_ctl == rfpc_pkg::ST_RUN_VALUE |-> s_r.mode == rfpc_pkg::ST_RX;
    endproperty
    a_run_enters_rx: assert property (p_run_enters_rx) else $error("0x05 did not enter receive"); // RQ18

    property p_zero_sleeps;
        @(posedge sys_clk) disable iff (sys_rst)
        s_r.st_ctl == rfpc_pkg::ST_SLEEP_VALUE |-> s_r.mode == rfpc_pkg::ST_SLEEP;
    endproperty
    a_zero_sleeps: assert property (p_zero_sleeps) else $error("0x00 did not enter sleep"); // RQ18

    property p_det_only_poll;
        @(posedge sys_clk) disable iff (sys_rst)
        tif.detect_on |-> s_r.mode == rfpc_pkg::ST_POLL;
    endproperty
    a_det_only_poll: assert property (p_det_only_poll) else $error("detect window outside polling"); // RQ13

    property p_poll_wake;
        @(posedge sys_clk) disable iff (sys_rst)
        ce && s_r.mode == rfpc_pkg::ST_POLL && tif.detect_on && preamble_found
            && s_nxt.st_ctl[rfpc_pkg::ST_ENABLE_BIT] |=> s_r.mode == rfpc_pkg::ST_RX;
    endproperty
    a_poll_wake: assert property (p_poll_wake) else $error("preamble in detect window did not wake"); // RQ13

    c_rx_packet: cover property (@(posedge sys_clk) disable iff (sys_rst)
        s_r.mode == rfpc_pkg::ST_RX && packet_seen);
    c_poll_wrap: cover property (@(posedge sys_clk) disable iff (sys_rst) tif.cycle_wrap);
    c_poll_wake: cover property (@(posedge sys_clk) disable iff (sys_rst)
        s_r.mode == rfpc_pkg::ST_POLL ##1 s_r.mode == rfpc_pkg::ST_RX);
    c_lo_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
        s_r.mode == rfpc_pkg::ST_STANDBY && $changed(lo_word));
endmodule : rfpc_ctrl

/* File: test/rfpc_host_model.sv */
// microcontroller model driving the register interface in spi mode 0
`timescale 1ns/100ps
module rfpc_host_model (
    input  wire logic sys_clk,
    output logic      spi_cs_n,
    output logic      spi_sclk,
    output logic      spi_mosi,
    input  wire logic spi_miso_o,
    input  wire logic spi_miso_oe
);
    localparam int HALF = 4;

    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end

    task automatic wait_fall(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_fall

    // mosi changes with the falling sclk, miso is taken just before the rise
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            wait_fall(HALF);
            // an undriven line reads as the inverse so a missing enable shows up
            rx[i] = spi_miso_oe ? spi_miso_o : ~spi_miso_o;
            spi_sclk = 1'b1;
            wait_fall(HALF);
            spi_sclk = 1'b0;
        end
    endtask : shift_byte

    // command byte then data bytes; address steps on after every data byte
    task automatic frame(input logic wr, input logic [6:0] addr, input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        @(negedge sys_clk);
        spi_cs_n = 1'b0;
        wait_fall(HALF);
        shift_byte({wr, addr}, b);
        foreach (tx[i]) begin
            shift_byte(tx[i], b);
            rx.push_back(b);
        end
        wait_fall(HALF);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        wait_fall(HALF);
    endtask : frame
endmodule : rfpc_host_model

/* File: test/rfpc_ctrl_tb_top.sv */
// self-checking bench for the frequency tracking and polling controller
`timescale 1ns/100ps
module rfpc_ctrl_tb_top;
    logic        sys_clk;
    logic        sys_rst;
    logic        ce;
    logic        spi_cs_n;
    logic        spi_sclk;
    logic        spi_mosi;
    logic        spi_miso_o;
    logic        spi_miso_oe;
    logic        packet_seen;
    logic [9:0]  afc_error;
    logic        preamble_found;
    logic [23:0] synth_word_r;
    logic [4:0]  preamble_bits_r;
    logic [3:0]  mode_r;
    logic        detect_on_r;
    logic [7:0]  frontend_r;
    int          failures     = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    logic [7:0]  q[$];
    logic [7:0]  r[$];
    logic [7:0]  d;
    // last two bytes are the preamble match words, zero for manchester
    logic [7:0]  bank [15]  = '{8'h46, 8'h27, 8'h08, 8'h24, 8'hA7, 8'h09, 8'h0A, 8'h1F,
                                8'h00, 8'h1B, 8'h1B, 8'h85, 8'h0F, 8'h00, 8'h00};
    logic [7:0]  st_val [4] = '{8'h01, 8'h05, 8'h09, 8'h00};
    logic [3:0]  st_exp [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
    logic [2:0]  lim [5]    = '{3'd3, 3'd0, 3'd7, 3'd7, 3'd7};
    logic [9:0]  err [5]    = '{10'h064, 10'h014, 10'h12C, 10'h2D4, 10'h3A3};
    logic [7:0]  fexp [5]   = '{8'h30, 8'h00, 8'h70, 8'h90, 8'hA3};
    logic [7:0]  pcnt [2]   = '{8'h01, 8'h00};
    logic [6:0]  prat [2]   = '{7'h02, 7'h00};

    rfpc_ctrl #(.DET_BASE(4), .DET_STEP(2)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .packet_seen(packet_seen),
        .afc_error(afc_error), .preamble_found(preamble_found), .synth_word_r(synth_word_r),
        .preamble_bits_r(preamble_bits_r), .mode_r(mode_r), .detect_on_r(detect_on_r), .frontend_r(frontend_r));

    rfpc_host_model u_host (
        .sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] rr[$];
        u_host.frame(1'b1, a, {v}, rr);
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        logic [7:0] rr[$];
        u_host.frame(1'b0, a, {8'h00}, rr);
        v = rr[0];
    endtask : rd

    task automatic wait_det(input logic v);
        int n;
        n = 0;
        while (detect_on_r !== v && n < 500) begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_det

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        packet_seen = 1'b0;
        afc_error = 10'h000;
        preamble_found = 1'b0;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        chk(mode_r, 4'h1);
        chk(synth_word_r, 24'h00_0000);
        chk(preamble_bits_r, 5'h01);
        chk(spi_miso_oe, 1'b0);
        foreach (bank[i]) q.push_back(bank[i]);
        u_host.frame(1'b1, 7'h00, q, r);
        wr(rfpc_pkg::ADDR_FRONTEND, 8'h95);
        chk(frontend_r, 8'h95);
        chk(preamble_bits_r, 5'h10);
        chk(synth_word_r, 24'h1B_1B85);
        u_host.frame(1'b0, 7'h00, q, r);
        foreach (bank[i]) chk(r[i], bank[i]);
        rd(7'h30, d);
        chk(d, 8'h00);
        wr(rfpc_pkg::ADDR_PREAMBLE, 8'h00);
        chk(preamble_bits_r, 5'h01);
        foreach (st_val[i]) begin
            wr(rfpc_pkg::ADDR_STATE, st_val[i]);
            chk(mode_r, st_exp[i]);
        end
        wr(rfpc_pkg::ADDR_STATE, 8'h05);
        foreach (lim[i]) begin
            wr(7'h01, {5'b00100, lim[i]});
            @(negedge sys_clk);
            afc_error = err[i];
            packet_seen = 1'b1;
            @(negedge sys_clk);
            packet_seen = 1'b0;
            afc_error = ~err[i];
            rd(rfpc_pkg::ADDR_FEI, d);
            chk(d, fexp[i]);
        end
        wr(rfpc_pkg::ADDR_FEI, 8'h55);
        rd(rfpc_pkg::ADDR_FEI, d);
        chk(d, 8'hA3);
        chk(synth_word_r, 24'h1B_1ACB);
        u_host.frame(1'b1, rfpc_pkg::ADDR_LO_HI, {8'h00, 8'h00, 8'h00}, r);
        u_host.frame(1'b0, rfpc_pkg::ADDR_LO_HI, {8'h00, 8'h00, 8'h00}, r);
        chk({r[0], r[1], r[2]}, 24'h1B_1B85);
        // retune: index -93 with shift 1 lowers the word by 186 counts
        wr(rfpc_pkg::ADDR_STATE, 8'h01);
        u_host.frame(1'b1, rfpc_pkg::ADDR_LO_HI, {8'h1B, 8'h1A, 8'hCB}, r);
        chk(mode_r, 4'h2);
        chk(synth_word_r, 24'h1B_1ACB);
        for (int k = 0; k < 2; k++) begin
            int hi;
            wr(rfpc_pkg::ADDR_WAKE_DET, pcnt[k]);
            wr(rfpc_pkg::ADDR_RATIO, {1'b1, prat[k]});
            rd(rfpc_pkg::ADDR_RATIO, d);
            chk(d, {1'b0, prat[k]});
            wr(rfpc_pkg::ADDR_STATE, 8'h09);
            wait_det(1'b0);
            wait_det(1'b1);
            hi = 0;
            while (detect_on_r === 1'b1 && hi < 500) begin
                @(negedge sys_clk);
                hi++;
            end
            chk(hi, 4 + 2 * pcnt[k]);
            hi = 0;
            repeat (240) begin
                @(negedge sys_clk);
                if (detect_on_r === 1'b1) hi++;
            end
            chk(hi, 240 / (prat[k] + 2));
            wait_det(1'b0);
            wait_det(1'b1);
            @(negedge sys_clk);
            preamble_found = 1'b1;
            @(negedge sys_clk);
            preamble_found = 1'b0;
            repeat (3) @(negedge sys_clk);
            chk(mode_r, 4'h4);
            wr(rfpc_pkg::ADDR_STATE, 8'h00);
        end
        // with the clock enable low a whole write frame must leave no trace
        ce = 1'b0;
        wr(rfpc_pkg::ADDR_FRONTEND, 8'h11);
        chk(frontend_r, 8'h95);
        ce = 1'b1;
        rd(rfpc_pkg::ADDR_FRONTEND, d);
        chk(d, 8'h95);
        tally_and_finish();
    end
endmodule : rfpc_ctrl_tb_top
